/* src/ctl_reg_store_load.sv */
// store/load control register and change addressing mode execution logic
// assumes a same-clock sequencer, a character memory with an ack, an AHB-Lite master
// Function
// - store writes selected register into A field
// - two-char store writes low twelve bits
// - three-char store writes fifteen bits, top zeroed
// - four-char store zero pads register to field
// - only multicharacter writes top character in four-char
// - bits beyond installed memory stored as zero
// - variant code selects counter or named register
// - missing variant reuses the held variant
// - missing A address uses A-address register
// - storing code 67 gives previous A address
// - work register saves and restores A address
// - punctuation bits neither sensed nor changed
// - two-char load replaces low twelve bits only
// - three-char load replaces low fifteen bits only
// - four-char load sized by memory, multicharacter nineteen
// - privileged load exempt only under five conditions
// - load to sequence register redirects next fetch
// - mode change sets length, trap and S modes
// - mode variant decodes length, trap and S bits
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
module ctl_reg_store_load (
  input  logic                           sys_clk_i,
  input  logic                           rst_b_i,
  input  logic                           hsel_i,
  input  logic [31:0]                    haddr_i,
  input  logic [1:0]                     htrans_i,
  input  logic                           hwrite_i,
  input  logic [2:0]                     hsize_i,
  input  logic [31:0]                    hwdata_i,
  input  logic                           hready_i,
  output logic [31:0]                    hrdata_o,
  output logic                           hreadyout_o,
  output logic                           hresp_o,
  input  logic                           cmd_valid_i,
  output logic                           cmd_ready_o,
  input  ctl_reg_pkg::op_e               cmd_op_i,
  input  logic                           cmd_has_variant_i,
  input  logic [5:0]                     cmd_variant_i,
  input  logic                           cmd_has_a_i,
  input  logic [ctl_reg_pkg::ADDR_W-1:0] cmd_a_addr_i,
  input  logic                           privilege_grant_op_i,
  input  logic                           storage_protect_i,
  input  logic                           base_mode_i,
  input  logic                           proceed_allow_i,
  output logic                           mem_req_o,
  output logic                           mem_we_o,
  output logic [ctl_reg_pkg::ADDR_W-1:0] mem_addr_o,
  output logic [ctl_reg_pkg::CHAR_W-1:0] mem_wdata_o,
  input  logic [ctl_reg_pkg::CHAR_W-1:0] mem_rdata_i,
  input  logic                           mem_ack_i,
  output logic                           done_o,
  output logic                           violation_o,
  output logic                           branch_o,
  output ctl_reg_pkg::addr_mode_e        addr_mode_o,
  output logic                           trap_mode_o,
  output logic                           s_mode_o,
  output logic [ctl_reg_pkg::ADDR_W-1:0] a_addr_reg_o,
  output logic [ctl_reg_pkg::ADDR_W-1:0] b_addr_reg_o,
  output logic [ctl_reg_pkg::ADDR_W-1:0] seq_reg_o,
  output logic                           irq_o
);
  import ctl_reg_pkg::*;

  typedef enum logic [1:0] {st_idle, st_xfer, st_finish} state_e;

  state_e             state_ff;
  logic [ADDR_W-1:0]  ctrl_ff [NUM_REGS];
  logic [ADDR_W-1:0]  aar_ff;
  logic [5:0]         var_ff;
  logic [5:0]         idx_ff;
  logic               is_load_ff;
  logic               xfer_ok_ff;
  logic [2:0]         cnt_ff;
  logic [2:0]         nchars_ff;
  logic [FIELD_W-1:0] sfield_ff;
  logic [FIELD_W-1:0] acc_ff;
  logic [ADDR_W-1:0]  maddr_ff;
  addr_mode_e         mode_ff;
  logic               trap_ff;
  logic               smode_ff;
  logic               grant_ff;
  logic               done_ff;
  logic               viol_ff;
  logic               branch_ff;
  logic               multi_ff;
  logic [4:0]         membits_ff;
  logic [ST_W-1:0]    status_ff;
  logic [ST_W-1:0]    mask_ff;
  logic [31:0]        hrdata_ff;
  logic               wr_pend_ff;
  logic [7:0]         wr_addr_ff;

  // command decode
  wire       idle     = state_ff == st_idle;
  wire       accept   = cmd_valid_i && idle;
  wire       acc_mode = accept && cmd_op_i == change_address_mode_op;
  wire       acc_sl   = accept && cmd_op_i != change_address_mode_op;
  wire       acc_load = accept && cmd_op_i == load_control_register_op;
  wire [5:0] sel_code = cmd_has_variant_i ? cmd_variant_i : var_ff;
  wire [5:0] sel_idx  = (sel_code <= CODE_CNT_LAST) ? sel_code :
                        (sel_code == CODE_ATTN)     ? IDX_ATTN :
                        (sel_code == CODE_CSR)      ? IDX_CSR :
                        (sel_code == CODE_EXT)      ? IDX_EXT :
                        (sel_code == CODE_WORK)     ? IDX_WORK :
                        (sel_code == CODE_BADDR)    ? IDX_BADDR :
                        (sel_code == CODE_INT)      ? IDX_INT :
                        (sel_code == CODE_SEQ)      ? IDX_SEQ : IDX_NONE;
  wire       sel_ok   = sel_idx != IDX_NONE;
  wire       priv_code = sel_code == CODE_CSR || sel_code == CODE_WORK ||
                         sel_code == CODE_BADDR || sel_code == CODE_SEQ;
  wire       exempt   = grant_ff && priv_code && storage_protect_i && base_mode_i &&
                        !proceed_allow_i;
  wire       viol     = acc_load && storage_protect_i && !exempt;
  wire       go_mem   = acc_sl && sel_ok && !viol;
  wire [ADDR_W-1:0] field_addr = cmd_has_a_i ? cmd_a_addr_i : aar_ff;
  // code 67 reads the A address as it was before this instruction
  wire [ADDR_W-1:0] src_val = (sel_idx == IDX_WORK) ? aar_ff :
                              sel_ok ? ctrl_ff[sel_idx] : '0;
  wire [ADDR_W-1:0] shp_reg = idle ? src_val : ctrl_ff[idx_ff];
  wire              last    = cnt_ff == nchars_ff - 3'h1;
  wire              fin     = state_ff == st_finish;
  wire              ld_fin  = fin && is_load_ff && xfer_ok_ff;
  wire [1:0]        len_fld = sel_code[LEN_LSB+1:LEN_LSB];
  wire [FIELD_W-1:0] store_field;
  wire [2:0]         nchars;
  wire [ADDR_W-1:0]  load_value;

  field_shaper u_shaper (
    .mode_i        (mode_ff),
    .multi_i       (multi_ff),
    .mem_bits_i    (membits_ff),
    .reg_val_i     (shp_reg),
    .field_i       (acc_ff),
    .store_field_o (store_field),
    .nchars_o      (nchars),
    .load_val_o    (load_value)
  );

  // control memory; one write port per slot
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_ctrl
    wire save_w = acc_sl && 6'(i) == IDX_WORK;
    wire load_w = ld_fin && idx_ff == 6'(i);
    always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
        ctrl_ff[i] <= '0;
      end else if (load_w) begin
        ctrl_ff[i] <= load_value;
      end else if (save_w) begin
        ctrl_ff[i] <= aar_ff;
      end
    end
  end

  // A-address register: operand address in, work register back at the end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      aar_ff <= '0;
    end else if (acc_sl && cmd_has_a_i) begin
      aar_ff <= cmd_a_addr_i;
    end else if (fin) begin
      aar_ff <= (ld_fin && idx_ff == IDX_WORK) ? load_value : ctrl_ff[IDX_WORK];
    end
  end

  // held variant, privilege grant and modes
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      var_ff   <= '0;
      grant_ff <= 1'b0;
      mode_ff  <= MODE_RST;
      trap_ff  <= 1'b0;
      smode_ff <= 1'b0;
    end else begin
      if (accept && cmd_has_variant_i) var_ff <= cmd_variant_i;
      if (privilege_grant_op_i) grant_ff <= 1'b1;
      if (acc_mode) begin
        mode_ff  <= (len_fld == LEN_TWO) ? addr_two :
                    (len_fld == LEN_FOUR) ? addr_four : addr_three;
        trap_ff  <= sel_code[TRAP_BIT];
        smode_ff <= sel_code[S_BIT];
      end
    end
  end

  // operation sequencer
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_ff   <= st_idle;
      idx_ff     <= '0;
      is_load_ff <= 1'b0;
      xfer_ok_ff <= 1'b0;
      cnt_ff     <= '0;
      nchars_ff  <= '0;
      sfield_ff  <= '0;
      acc_ff     <= '0;
      maddr_ff   <= '0;
      done_ff    <= 1'b0;
      viol_ff    <= 1'b0;
      branch_ff  <= 1'b0;
    end else begin
      done_ff   <= acc_mode || fin;
      viol_ff   <= viol;
      branch_ff <= ld_fin && idx_ff == IDX_SEQ;
      case (state_ff)
        st_idle: begin
          if (acc_sl) begin
            state_ff   <= go_mem ? st_xfer : st_finish;
            idx_ff     <= sel_idx;
            is_load_ff <= cmd_op_i == load_control_register_op;
            xfer_ok_ff <= go_mem;
            cnt_ff     <= '0;
            nchars_ff  <= nchars;
            sfield_ff  <= store_field;
            acc_ff     <= '0;
            maddr_ff   <= field_addr;   // units position first
          end
        end
        st_xfer: begin
          if (mem_ack_i) begin
            acc_ff[6*cnt_ff +: CHAR_W] <= mem_rdata_i;
            sfield_ff <= sfield_ff >> CHAR_W;
            maddr_ff  <= maddr_ff - ADDR_ONE;
            cnt_ff    <= cnt_ff + 3'h1;
            if (last) state_ff <= st_finish;
          end
        end
        st_finish: state_ff <= st_idle;
        default:   state_ff <= st_idle;
      endcase
    end
  end

  // memory port carries data bits only, so punctuation is untouched
  assign mem_req_o   = state_ff == st_xfer;
  assign mem_we_o    = !is_load_ff;
  assign mem_addr_o  = maddr_ff;
  assign mem_wdata_o = sfield_ff[CHAR_W-1:0];

  assign cmd_ready_o  = idle;
  assign done_o       = done_ff;
  assign violation_o  = viol_ff;
  assign branch_o     = branch_ff;
  assign addr_mode_o  = mode_ff;
  assign trap_mode_o  = trap_ff;
  assign s_mode_o     = smode_ff;
  assign a_addr_reg_o = aar_ff;
  assign b_addr_reg_o = ctrl_ff[IDX_BADDR];
  assign seq_reg_o    = ctrl_ff[IDX_SEQ];

  // AHB-Lite slave, zero wait states
  wire        ahb_act  = hsel_i && htrans_i[1] && hready_i;
  wire        ahb_rd   = ahb_act && !hwrite_i;
  wire [7:0]  ahb_ofs  = haddr_i[7:0];
  wire        ahb_hit  = haddr_i[31:8] == 24'h000000;
  wire        st_clr   = ahb_rd && ahb_hit && ahb_ofs == OFS_STATUS;
  wire        cfg_wr   = wr_pend_ff && wr_addr_ff == OFS_CONFIG;
  wire        mask_wr  = wr_pend_ff && wr_addr_ff == OFS_MASK;
  wire [31:0] mode_rd  = {28'h0000000, smode_ff, trap_ff, mode_ff};
  wire [31:0] cfg_rd   = {19'h00000, membits_ff, 7'h00, multi_ff};
  wire [31:0] rd_mux   = !ahb_hit               ? 32'h00000000 :
                         ahb_ofs == OFS_CONFIG  ? cfg_rd :
                         ahb_ofs == OFS_MODE    ? mode_rd :
                         ahb_ofs == OFS_STATUS  ? {28'h0000000, status_ff} :
                         ahb_ofs == OFS_MASK    ? {28'h0000000, mask_ff} :
                         ahb_ofs == OFS_AADDR   ? {13'h0000, aar_ff} :
                         ahb_ofs == OFS_SEQ     ? {13'h0000, seq_reg_o} : 32'h00000000;
  wire [ST_W-1:0] st_set;

  assign st_set[ST_STORE] = fin && xfer_ok_ff && !is_load_ff;
  assign st_set[ST_LOAD]  = ld_fin;
  assign st_set[ST_MODE]  = acc_mode;
  assign st_set[ST_VIOL]  = viol_ff;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      hrdata_ff  <= '0;
    end else begin
      wr_pend_ff <= ahb_act && hwrite_i && ahb_hit;
      wr_addr_ff <= ahb_ofs;
      if (ahb_rd) hrdata_ff <= rd_mux;
    end
  end

  // a set in the clearing cycle survives the read
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      status_ff  <= '0;
      mask_ff    <= MASK_RST;
      multi_ff   <= CFG_MULTI_RST;
      membits_ff <= CFG_BITS_RST;
    end else begin
      status_ff <= (status_ff & ~{ST_W{st_clr}}) | st_set;
      if (mask_wr) mask_ff <= hwdata_i[ST_W-1:0];
      if (cfg_wr) begin
        multi_ff   <= hwdata_i[CFG_MULTI_BIT];
        membits_ff <= hwdata_i[CFG_BITS_LSB+4:CFG_BITS_LSB];
      end
    end
  end

  assign hrdata_o    = hrdata_ff;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign irq_o       = |(status_ff & mask_ff);

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_mode_cmd(logic [5:0] code);
    acc_mode && sel_code == code;
  endsequence
  sequence s_finish;
    state_ff == st_finish;
  endsequence

  property p_cam_two;
    s_mode_cmd(MODE_VAR_TWO) |=> mode_ff == addr_two && !trap_ff && !smode_ff;
  endproperty
  a_cam_two: assert property (p_cam_two) else $error("mode 20 not two-char standard");
  property p_cam_four_ts;
    s_mode_cmd(MODE_VAR_FOUR_TS) |=> mode_ff == addr_four && trap_ff && smode_ff;
  endproperty
  a_cam_four_ts: assert property (p_cam_four_ts) else $error("mode 74 decode wrong");
  property p_cam_flags;
    acc_mode |=> trap_ff == $past(sel_code[TRAP_BIT]) && smode_ff == $past(sel_code[S_BIT]);
  endproperty
  a_cam_flags: assert property (p_cam_flags) else $error("trap or S flag wrong");
  property p_work_save;
    acc_sl |=> ctrl_ff[IDX_WORK] == $past(aar_ff);
  endproperty
  a_work_save: assert property (p_work_save) else $error("work register not saved");
  property p_work_restore;
    s_finish ##0 !(ld_fin && idx_ff == IDX_WORK) |=> aar_ff == $past(ctrl_ff[IDX_WORK]);
  endproperty
  a_work_restore: assert property (p_work_restore) else $error("A address not restored");
  property p_keep_variant;
    accept && !cmd_has_variant_i |=> var_ff == $past(var_ff);
  endproperty
  a_keep_variant: assert property (p_keep_variant) else $error("held variant changed");
  property p_first_addr;
    go_mem |=> mem_req_o && mem_addr_o == $past(field_addr) && cnt_ff == 3'h0;
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("first access not units position");
  property p_three_top;
    mem_req_o && mem_we_o && mode_ff == addr_three && cnt_ff == 3'h2 |-> mem_wdata_o[5:3] == 3'h0;
  endproperty
  a_three_top: assert property (p_three_top) else $error("three-char top bits not zero");
  property p_two_len;
    mem_req_o && mode_ff == addr_two |-> cnt_ff < CHARS_TWO;
  endproperty
  a_two_len: assert property (p_two_len) else $error("two-char access too long");
  property p_skip_top;
    mem_req_o && mode_ff == addr_four && !multi_ff |-> cnt_ff < CHARS_THREE;
  endproperty
  a_skip_top: assert property (p_skip_top) else $error("top character touched");
  property p_viol;
    acc_load && storage_protect_i && !grant_ff |=> violation_o && !mem_req_o ##1 done_o;
  endproperty
  a_viol: assert property (p_viol) else $error("privileged load not refused");
  property p_branch;
    s_finish ##0 (ld_fin && idx_ff == IDX_SEQ) |=> branch_o && seq_reg_o == $past(load_value);
  endproperty
  a_branch: assert property (p_branch) else $error("sequence register not loaded");
endmodule // ctl_reg_store_load

/* src/ctl_reg_pkg.sv */
// constants and types shared by the control register store/load logic
// assumes 6-bit characters and a 19-bit character address space
package ctl_reg_pkg;
  localparam int unsigned       ADDR_W   = 19;
  localparam int unsigned       CHAR_W   = 6;
  localparam int unsigned       FIELD_W  = 24;
  localparam int unsigned       NUM_REGS = 39;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 19'h00001;

  // variant codes that select control registers
  localparam logic [5:0] CODE_CNT_LAST = 6'h1f;
  localparam logic [5:0] CODE_ATTN     = 6'h2c;
  localparam logic [5:0] CODE_CSR      = 6'h34;
  localparam logic [5:0] CODE_EXT      = 6'h36;
  localparam logic [5:0] CODE_WORK     = 6'h37;
  localparam logic [5:0] CODE_BADDR    = 6'h38;
  localparam logic [5:0] CODE_INT      = 6'h3e;
  localparam logic [5:0] CODE_SEQ      = 6'h3f;

  // slots of the control memory array; counters take slots 0 to 31
  localparam logic [5:0] IDX_ATTN  = 6'h20;
  localparam logic [5:0] IDX_CSR   = 6'h21;
  localparam logic [5:0] IDX_EXT   = 6'h22;
  localparam logic [5:0] IDX_WORK  = 6'h23;
  localparam logic [5:0] IDX_BADDR = 6'h24;
  localparam logic [5:0] IDX_INT   = 6'h25;
  localparam logic [5:0] IDX_SEQ   = 6'h26;
  localparam logic [5:0] IDX_NONE  = 6'h3f;

  // fields of the mode-selection variant
  localparam int unsigned TRAP_BIT = 2;
  localparam int unsigned S_BIT    = 3;
  localparam int unsigned LEN_LSB  = 4;
  localparam logic [1:0]  LEN_TWO  = 2'h1;
  localparam logic [1:0]  LEN_FOUR = 2'h3;
  localparam logic [5:0]  MODE_VAR_TWO     = 6'h10;
  localparam logic [5:0]  MODE_VAR_FOUR_TS = 6'h3c;

  // address widths and field lengths per addressing mode
  localparam logic [4:0] BITS_TWO    = 5'h0c;
  localparam logic [4:0] BITS_THREE  = 5'h0f;
  localparam logic [4:0] BITS_FOUR   = 5'h12;
  localparam logic [4:0] BITS_MULTI  = 5'h13;
  localparam logic [2:0] CHARS_TWO   = 3'h2;
  localparam logic [2:0] CHARS_THREE = 3'h3;
  localparam logic [2:0] CHARS_MULTI = 3'h4;

  // register map
  localparam logic [7:0]  OFS_CONFIG = 8'h00;
  localparam logic [7:0]  OFS_MODE   = 8'h04;
  localparam logic [7:0]  OFS_STATUS = 8'h08;
  localparam logic [7:0]  OFS_MASK   = 8'h0c;
  localparam logic [7:0]  OFS_AADDR  = 8'h10;
  localparam logic [7:0]  OFS_SEQ    = 8'h14;
  localparam int unsigned CFG_MULTI_BIT = 0;
  localparam int unsigned CFG_BITS_LSB  = 8;
  localparam int unsigned MODE_TRAP_BIT = 2;
  localparam int unsigned MODE_S_BIT    = 3;
  localparam int unsigned ST_STORE = 0;
  localparam int unsigned ST_LOAD  = 1;
  localparam int unsigned ST_MODE  = 2;
  localparam int unsigned ST_VIOL  = 3;
  localparam int unsigned ST_W     = 4;
  localparam logic        CFG_MULTI_RST = 1'b0;
  localparam logic [4:0]  CFG_BITS_RST  = 5'h12;
  localparam logic [3:0]  MASK_RST      = 4'h0;

  typedef enum logic [1:0] {addr_two, addr_three, addr_four} addr_mode_e;
  typedef enum logic [1:0] {
    store_control_register_op,
    load_control_register_op,
    change_address_mode_op
  } op_e;

  localparam addr_mode_e MODE_RST = addr_three;
endpackage

/* src/field_shaper.sv */
// shapes a register value into a memory field and a memory field into a register value
// assumes mode and installation bits are stable while an operation runs
module field_shaper (
  input  ctl_reg_pkg::addr_mode_e        mode_i,
  input  logic                           multi_i,
  input  logic [4:0]                     mem_bits_i,
  input  logic [ctl_reg_pkg::ADDR_W-1:0] reg_val_i,
  input  logic [ctl_reg_pkg::FIELD_W-1:0] field_i,
  output logic [ctl_reg_pkg::FIELD_W-1:0] store_field_o,
  output logic [2:0]                     nchars_o,
  output logic [ctl_reg_pkg::ADDR_W-1:0] load_val_o
);
  import ctl_reg_pkg::*;

  wire [4:0] wbits = (mode_i == addr_two)   ? BITS_TWO :
                     (mode_i == addr_three) ? BITS_THREE :
                     multi_i                ? BITS_MULTI : BITS_FOUR;
  // store width never exceeds the installed memory size
  wire [4:0] sbits = (wbits < mem_bits_i) ? wbits : mem_bits_i;
  wire [4:0] lbits = (mode_i == addr_four && !multi_i) ? sbits : wbits;

  // non-multicharacter four-char store leaves the top character alone
  assign nchars_o = (mode_i == addr_two) ? CHARS_TWO :
                    (mode_i == addr_four && multi_i) ? CHARS_MULTI : CHARS_THREE;
  assign store_field_o[FIELD_W-1:ADDR_W] = '0;

  for (genvar b = 0; b < ADDR_W; b++) begin : g_bit
    // unused high bits of the field are written as zeros
    assign store_field_o[b] = (5'(b) < sbits) & reg_val_i[b];
    // two/three-char loads keep bank or sector bits
    assign load_val_o[b] = (5'(b) < lbits)     ? field_i[b] :
                           (mode_i == addr_four) ? 1'b0 : reg_val_i[b];
  end
endmodule // field_shaper

/* sim/char_mem_model.sv */
// behavioural character memory facing the block's memory port
// assumes one request at a time, held until acknowledged
module char_mem_model (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [18:0] addr_i,
  input  wire logic [5:0]  wdata_i,
  output logic [5:0]       rdata_o,
  output logic             ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] mem [0:4095];
  logic       wait_ff = 1'b0;
  // slow mode stretches every access by one cycle
  assign ack_o   = req_i && (!slow_i || wait_ff);
  // data lines carry the inverse outside an acknowledged access
  assign rdata_o = ack_o ? mem[addr_i[11:0]] : ~mem[addr_i[11:0]];
  always @(posedge clk_i) begin
    wait_ff <= req_i && !ack_o;
    if (req_i && ack_o && we_i) begin
      mem[addr_i[11:0]] <= wdata_i;
    end
  end
endmodule // char_mem_model

/* sim/control_register_store_load_test.sv */
// self-checking bench for the control register store/load block
// assumes the character memory model above and a bus master written here
module control_register_store_load_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ctl_reg_pkg::*;
  logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, cv = 0, hv = 0, ha = 0;
  logic grant = 0, prot = 0, base = 0, proc = 0, slow = 0, v_seen, b_seen;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0]  htrans = 0;
  logic [5:0]  var_c = 0, wd, rd;
  logic [18:0] aop = 0, maddr, a_operand_address_reg, bar, seq;
  logic        hrdy, hresp, crdy, req, we, ack, done, viol, br, ts, ss, irq;
  op_e         op = change_address_mode_op;
  addr_mode_e  mode;
  int          errors = 0, n_checks = 0;
  always #2 clk = ~clk;
  ctl_reg_store_load dut (.sys_clk_i(clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .cmd_valid_i(cv), .cmd_ready_o(crdy),
    .cmd_op_i(op), .cmd_has_variant_i(hv), .cmd_variant_i(var_c), .cmd_has_a_i(ha),
    .cmd_a_addr_i(aop), .privilege_grant_op_i(grant), .storage_protect_i(prot),
    .base_mode_i(base), .proceed_allow_i(proc), .mem_req_o(req), .mem_we_o(we),
    .mem_addr_o(maddr), .mem_wdata_o(wd), .mem_rdata_i(rd), .mem_ack_i(ack), .done_o(done),
    .violation_o(viol), .branch_o(br), .addr_mode_o(mode), .trap_mode_o(ts), .s_mode_o(ss),
    .a_addr_reg_o(a_operand_address_reg), .b_addr_reg_o(bar), .seq_reg_o(seq), .irq_o(irq));
  char_mem_model mem_m (.clk_i(clk), .slow_i(slow), .req_i(req), .we_i(we), .addr_i(maddr),
    .wdata_i(wd), .rdata_o(rd), .ack_o(ack));
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkc(input logic [18:0] a, input logic [5:0] e);
    chk({26'h0, mem_m.mem[a[11:0]]}, {26'h0, e});
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
    hsel <= 0;
  endtask
  task automatic run(input op_e o, input logic hvi, input logic [5:0] v, input logic hai,
                     input logic [18:0] a);
    @(posedge clk);
    cv <= 1; op <= o; hv <= hvi; var_c <= v; ha <= hai; aop <= a;
    do @(posedge clk); while (crdy !== 1'b1);
    cv <= 0; v_seen = 0; b_seen = 0;
    do begin
      @(posedge clk);
      v_seen |= viol;
      b_seen |= br;
    end while (done !== 1'b1);
  endtask
  task automatic t_reset();
    chk(mode, addr_three);
    chk(hresp, 1'b0);
    bus(0, 32'h00, 0); chk(r, 32'h1200);
    bus(0, 32'h40, 0); chk(r, 32'h0);
    bus(1, 32'h0c, 32'hf); bus(0, 32'h0c, 0); chk(r, 32'hf);
    $display("reset and registers test done");
  endtask
  task automatic t_modes();
    logic [5:0] vt [7] = '{6'h10, 6'h00, 6'h20, 6'h30, 6'h14, 6'h18, 6'h3c};
    logic [3:0] et [7] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h4, 4'h8, 4'he};
    for (int i = 0; i < 7; i++) begin
      run(change_address_mode_op, 1, vt[i], 0, 0);
      chk({ss, ts, mode}, et[i]);
    end
    bus(1, 32'h04, 0); bus(0, 32'h04, 0); chk(r, 32'he);
    chk(irq, 1'b1);
    bus(0, 32'h08, 0); chk(r, 32'h4);
    @(posedge clk); chk(irq, 1'b0);
    $display("mode change test done");
  endtask
  task automatic t_loads();
    mem_m.mem[98] = 6'h3f; mem_m.mem[99] = 6'h2a; mem_m.mem[100] = 6'h15;
    run(change_address_mode_op, 1, 6'h30, 0, 0);
    run(load_control_register_op, 1, 6'h38, 1, 100); chk(bar, 19'h3fa95);
    mem_m.mem[98] = 6'h00; mem_m.mem[100] = 6'h01;
    run(change_address_mode_op, 1, 6'h00, 0, 0);
    run(load_control_register_op, 1, 6'h38, 1, 100); chk(bar, 19'h38a81);
    mem_m.mem[100] = 6'h02;
    run(change_address_mode_op, 1, 6'h10, 0, 0);
    run(load_control_register_op, 1, 6'h38, 1, 100); chk(bar, 19'h38a82);
    run(change_address_mode_op, 1, 6'h30, 0, 0);
    slow <= 1;
    run(load_control_register_op, 1, 6'h3f, 1, 100); chk(seq, 19'h00a82);
    chk(b_seen, 1'b1);
    slow <= 0;
    $display("load test done");
  endtask
  task automatic t_stores();
    mem_m.mem[198] = 6'h3f; mem_m.mem[248] = 6'h3f; mem_m.mem[297] = 6'h2b;
    run(change_address_mode_op, 1, 6'h00, 0, 0);
    run(store_control_register_op, 1, 6'h38, 1, 200);
    chkc(200, 6'h02); chkc(199, 6'h2a); chkc(198, 6'h00);
    run(change_address_mode_op, 1, 6'h10, 0, 0);
    run(store_control_register_op, 1, 6'h38, 1, 250);
    chkc(250, 6'h02); chkc(249, 6'h2a); chkc(248, 6'h3f);
    run(change_address_mode_op, 1, 6'h30, 0, 0);
    run(store_control_register_op, 1, 6'h38, 1, 300);
    chkc(298, 6'h38); chkc(297, 6'h2b);
    bus(1, 32'h00, 32'h0e00);
    run(store_control_register_op, 1, 6'h38, 1, 500);
    chkc(500, 6'h02); chkc(498, 6'h00);
    bus(1, 32'h00, 32'h1301);
    mem_m.mem[797] = 6'h3f;
    run(store_control_register_op, 1, 6'h38, 1, 800);
    chkc(798, 6'h38);
    chkc(797, 6'h00);
    mem_m.mem[797] = 6'h3f;
    run(load_control_register_op, 1, 6'h38, 1, 800);
    chk(bar, 19'h78a82);
    bus(1, 32'h00, 32'h1200);
    $display("store test done");
  endtask
  task automatic t_priv();
    bus(0, 32'h08, 0);
    prot <= 1; base <= 1;
    run(load_control_register_op, 1, 6'h34, 1, 100); chk(v_seen, 1'b1);
    @(posedge clk); grant <= 1;
    @(posedge clk); grant <= 0;
    run(load_control_register_op, 1, 6'h34, 1, 100); chk(v_seen, 1'b0);
    run(load_control_register_op, 1, 6'h36, 1, 100); chk(v_seen, 1'b1);
    proc <= 1;
    run(load_control_register_op, 1, 6'h34, 1, 100); chk(v_seen, 1'b1);
    prot <= 0; proc <= 0; base <= 0;
    chk(irq, 1'b1);
    bus(0, 32'h08, 0); chk(r, 32'ha);
    $display("privileged load test done");
  endtask
  task automatic t_work();
    run(load_control_register_op, 1, 6'h37, 1, 100); chk(a_operand_address_reg, 19'h00a82);
    run(store_control_register_op, 0, 6'h00, 1, 400);
    chkc(400, 6'h02); chkc(399, 6'h2a);
    chk(a_operand_address_reg, 19'h00a82);
    run(store_control_register_op, 0, 6'h00, 0, 0);
    chkc(19'h00a82, 6'h02); chkc(19'h00a81, 6'h2a);
    run(load_control_register_op, 1, 6'h05, 1, 100);
    run(store_control_register_op, 1, 6'h05, 1, 600);
    chkc(600, 6'h02);
    chkc(599, 6'h2a);
    mem_m.mem[700] = 6'h15;
    run(store_control_register_op, 1, 6'h28, 1, 700);
    chkc(700, 6'h15);
    $display("work register test done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1;
    t_reset();
    t_modes();
    t_loads();
    t_stores();
    t_priv();
    t_work();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
endmodule // control_register_store_load_test
